// ### src/pdx_config_regs.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pdx_config_regs (
	input  wire logic        clk,            // 40 MHz device clock
	input  wire logic        rst_b,          // Async reset, active low
	input  wire logic [11:0] regAddr,        // Register index
	input  wire logic [15:0] regWrData,      // Write data
	input  wire logic        regWr,          // Write strobe
	input  wire logic        regRd,          // Read strobe
	output logic      [15:0] regRdData,      // Read data, cycle after strobe
	output logic      [3:0]  fineSwing,      // Fine driver gain code
	output logic      [2:0]  coarseSwing,    // Coarse driver gain code
	output logic             sixWireLink,    // Six-wire serial link selected
	output logic             recvClockOutEn, // Enable for receive clock pair
	output logic      [3:0]  txDelay,        // Transmit clock delay code
	output logic      [3:0]  rxDelay         // Receive clock delay code
);
	logic [15:0] fineReg;
	logic [15:0] coarseReg;
	logic [15:0] variantReg;
	logic [15:0] delayReg;
	logic [15:0] regRdData_nxt;
	logic [3:0]  fineSwing_nxt;
	logic [2:0]  coarseSwing_nxt;
	logic        sixWireLink_nxt;
	logic        recvClockOutEn_nxt;
	logic [3:0]  txDelay_nxt;
	logic [3:0]  rxDelay_nxt;
	logic        hitFine;
	logic        hitCoarse;
	logic        hitVariant;
	logic        hitDelay;
	logic        hitDischarge;

	// Address decode
	assign hitFine      = regAddr == pdx_pkg::FINE_SWING_ADDR;
	assign hitCoarse    = regAddr == pdx_pkg::COARSE_SWING_ADDR;
	assign hitVariant   = regAddr == pdx_pkg::LINK_VARIANT_ADDR;
	assign hitDelay     = regAddr == pdx_pkg::CLOCK_DELAY_ADDR;
	assign hitDischarge = regAddr == pdx_pkg::DISCHARGE_ADDR;

	// Fine swing register, full word writable
	pdx_reg16 #(.RST_VAL(pdx_pkg::FINE_SWING_RST), .WMASK(pdx_pkg::FINE_SWING_WMASK)) uFine (
		.clk    (clk),
		.rst_b  (rst_b),
		.wrEn   (regWr && hitFine),
		.wrData (regWrData),
		.value  (fineReg)
	);

	// Coarse swing register
	pdx_reg16 #(.RST_VAL(pdx_pkg::COARSE_SWING_RST), .WMASK(pdx_pkg::COARSE_SWING_WMASK)) uCoarse (
		.clk    (clk),
		.rst_b  (rst_b),
		.wrEn   (regWr && hitCoarse),
		.wrData (regWrData),
		.value  (coarseReg)
	);

	// Link variant register, top bit read-only zero
	pdx_reg16 #(.RST_VAL(pdx_pkg::LINK_VARIANT_RST), .WMASK(pdx_pkg::LINK_VARIANT_WMASK)) uVariant (
		.clk    (clk),
		.rst_b  (rst_b),
		.wrEn   (regWr && hitVariant),
		.wrData (regWrData),
		.value  (variantReg)
	);

	// Clock delay register, upper byte read-only zero
	pdx_reg16 #(.RST_VAL(pdx_pkg::CLOCK_DELAY_RST), .WMASK(pdx_pkg::CLOCK_DELAY_WMASK)) uDelay (
		.clk    (clk),
		.rst_b  (rst_b),
		.wrEn   (regWr && hitDelay),
		.wrData (regWrData),
		.value  (delayReg)
	);

	// Read mux; discharge status has no counters here, unmapped reads zero
	// Gated by the strobe so the port sits at zero between reads
	always_comb begin
		regRdData_nxt = pdx_pkg::RDATA_IDLE;
		if (regRd) begin
			if (hitFine) begin
				regRdData_nxt = fineReg;
			end else if (hitCoarse) begin
				regRdData_nxt = coarseReg;
			end else if (hitVariant) begin
				regRdData_nxt = variantReg;
			end else if (hitDelay) begin
				regRdData_nxt = delayReg;
			end else if (hitDischarge) begin
				regRdData_nxt = pdx_pkg::DISCHARGE_RST;
			end
		end
	end

	// Field outputs follow the stored words; the extra stage keeps every output flop-driven
	// at the cost of one more cycle between a write and the pins
	always_comb begin
		fineSwing_nxt      = fineReg[pdx_pkg::FINE_LSB +: pdx_pkg::NIBBLE_W];
		coarseSwing_nxt    = coarseReg[pdx_pkg::COARSE_LSB +: pdx_pkg::COARSE_W];
		sixWireLink_nxt    = variantReg[pdx_pkg::VARIANT_BIT];
		recvClockOutEn_nxt = variantReg[pdx_pkg::VARIANT_BIT];
		txDelay_nxt        = delayReg[pdx_pkg::TX_DELAY_LSB +: pdx_pkg::NIBBLE_W];
		rxDelay_nxt        = delayReg[pdx_pkg::RX_DELAY_LSB +: pdx_pkg::NIBBLE_W];
	end

	// Output registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			regRdData      <= pdx_pkg::RDATA_IDLE;
			fineSwing      <= pdx_pkg::FINE_SWING_RST[pdx_pkg::FINE_LSB +: pdx_pkg::NIBBLE_W];
			coarseSwing    <= pdx_pkg::COARSE_SWING_RST[pdx_pkg::COARSE_LSB +: pdx_pkg::COARSE_W];
			sixWireLink    <= pdx_pkg::LINK_VARIANT_RST[pdx_pkg::VARIANT_BIT];
			recvClockOutEn <= pdx_pkg::LINK_VARIANT_RST[pdx_pkg::VARIANT_BIT];
			txDelay        <= pdx_pkg::CLOCK_DELAY_RST[pdx_pkg::TX_DELAY_LSB +: pdx_pkg::NIBBLE_W];
			rxDelay        <= pdx_pkg::CLOCK_DELAY_RST[pdx_pkg::RX_DELAY_LSB +: pdx_pkg::NIBBLE_W];
		end else begin
			regRdData      <= regRdData_nxt;
			fineSwing      <= fineSwing_nxt;
			coarseSwing    <= coarseSwing_nxt;
			sixWireLink    <= sixWireLink_nxt;
			recvClockOutEn <= recvClockOutEn_nxt;
			txDelay        <= txDelay_nxt;
			rxDelay        <= rxDelay_nxt;
		end
	end

	// Fields reach their pins two cycles after the write edge
	fine_write_lands_a: assert property (@(posedge clk) disable iff (!rst_b)
		(regWr && hitFine) |->
		##2 fineSwing == $past(regWrData[pdx_pkg::FINE_LSB +: pdx_pkg::NIBBLE_W], 2))
		else $error("fine swing code not taken");
	coarse_write_lands_a: assert property (@(posedge clk) disable iff (!rst_b)
		(regWr && hitCoarse) |->
		##2 coarseSwing == $past(regWrData[pdx_pkg::COARSE_LSB +: pdx_pkg::COARSE_W], 2))
		else $error("coarse swing code not taken");
	variant_pair_tied_a: assert property (@(posedge clk) disable iff (!rst_b)
		sixWireLink == recvClockOutEn)
		else $error("receive clock enable differs from variant");
	variant_write_lands_a: assert property (@(posedge clk) disable iff (!rst_b)
		(regWr && hitVariant) |-> ##2 sixWireLink == $past(regWrData[pdx_pkg::VARIANT_BIT], 2))
		else $error("variant bit not taken");
	tx_delay_lands_a: assert property (@(posedge clk) disable iff (!rst_b)
		(regWr && hitDelay) |->
		##2 txDelay == $past(regWrData[pdx_pkg::TX_DELAY_LSB +: pdx_pkg::NIBBLE_W], 2))
		else $error("transmit delay not taken");
	rx_delay_lands_a: assert property (@(posedge clk) disable iff (!rst_b)
		(regWr && hitDelay) |->
		##2 rxDelay == $past(regWrData[pdx_pkg::RX_DELAY_LSB +: pdx_pkg::NIBBLE_W], 2))
		else $error("receive delay not taken");

	// Without a write two cycles back no field output may move, so a stray decode shows up
	fine_code_holds_a: assert property (@(posedge clk) disable iff (!rst_b)
		!$past(regWr && hitFine, 2) |-> $stable(fineSwing))
		else $error("fine swing code moved without a write");
	coarse_code_holds_a: assert property (@(posedge clk) disable iff (!rst_b)
		!$past(regWr && hitCoarse, 2) |-> $stable(coarseSwing))
		else $error("coarse swing code moved without a write");
	variant_holds_a: assert property (@(posedge clk) disable iff (!rst_b)
		!$past(regWr && hitVariant, 2) |-> $stable(sixWireLink) && $stable(recvClockOutEn))
		else $error("variant outputs moved without a write");
	delay_code_holds_a: assert property (@(posedge clk) disable iff (!rst_b)
		!$past(regWr && hitDelay, 2) |-> $stable(txDelay) && $stable(rxDelay))
		else $error("delay codes moved without a write");

	// Every release of reset leaves the default codes on the pins
	fine_reset_value_a: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(rst_b) |->
		fineSwing == pdx_pkg::FINE_SWING_RST[pdx_pkg::FINE_LSB +: pdx_pkg::NIBBLE_W])
		else $error("fine swing code wrong after reset");
	coarse_reset_value_a: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(rst_b) |->
		coarseSwing == pdx_pkg::COARSE_SWING_RST[pdx_pkg::COARSE_LSB +: pdx_pkg::COARSE_W])
		else $error("coarse swing code wrong after reset");
	variant_reset_value_a: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(rst_b) |->
		sixWireLink == pdx_pkg::LINK_VARIANT_RST[pdx_pkg::VARIANT_BIT])
		else $error("variant bit wrong after reset");
	delay_reset_value_a: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(rst_b) |->
		{txDelay, rxDelay} == pdx_pkg::CLOCK_DELAY_RST[pdx_pkg::RX_DELAY_LSB +: 2 * pdx_pkg::NIBBLE_W])
		else $error("delay codes wrong after reset");

	// Read port
	delay_upper_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
		(regRd && hitDelay) |=>
		(regRdData & ~pdx_pkg::CLOCK_DELAY_WMASK) == (pdx_pkg::CLOCK_DELAY_RST & ~pdx_pkg::CLOCK_DELAY_WMASK))
		else $error("delay reserved byte not zero");
	variant_top_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
		(regRd && hitVariant) |=>
		(regRdData & ~pdx_pkg::LINK_VARIANT_WMASK) == (pdx_pkg::LINK_VARIANT_RST & ~pdx_pkg::LINK_VARIANT_WMASK))
		else $error("variant read-only bit not zero");
	fine_readback_a: assert property (@(posedge clk) disable iff (!rst_b)
		(regWr && hitFine) ##1 (regRd && hitFine && !regWr) |=> regRdData == $past(regWrData, 2))
		else $error("fine readback mismatch");
	coarse_readback_a: assert property (@(posedge clk) disable iff (!rst_b)
		(regWr && hitCoarse) ##1 (regRd && hitCoarse && !regWr) |=> regRdData == $past(regWrData, 2))
		else $error("coarse readback mismatch");
	delay_readback_a: assert property (@(posedge clk) disable iff (!rst_b)
		(regWr && hitDelay) ##1 (regRd && hitDelay && !regWr) |=>
		regRdData == (($past(regWrData, 2) & pdx_pkg::CLOCK_DELAY_WMASK) |
		(pdx_pkg::CLOCK_DELAY_RST & ~pdx_pkg::CLOCK_DELAY_WMASK)))
		else $error("delay readback mismatch");
	unmapped_read_a: assert property (@(posedge clk) disable iff (!rst_b) // Bus contract
		(regRd && !(hitFine || hitCoarse || hitVariant || hitDelay || hitDischarge)) |=>
		regRdData == pdx_pkg::RDATA_IDLE)
		else $error("unmapped read not zero");
	idle_read_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // Bus contract
		(!regRd) |=> regRdData == pdx_pkg::RDATA_IDLE)
		else $error("read data without strobe");

	// Scenarios worth seeing at least once
	write_fine_c: cover property (@(posedge clk) regWr && hitFine);
	six_wire_c: cover property (@(posedge clk) sixWireLink);
	delay_max_c: cover property (@(posedge clk) txDelay == 4'hf && rxDelay == 4'hf);
	coarse_max_c: cover property (@(posedge clk) coarseSwing == 3'h7);
	readback_c: cover property (@(posedge clk) (regWr && hitCoarse) ##1 (regRd && hitCoarse));
endmodule
`default_nettype wire

// ### src/pdx_pkg.sv
package pdx_pkg;
	// Register indices; byte address would be twice these where a 16-bit word bus is used
	localparam logic [11:0] FINE_SWING_ADDR   = 12'h401;
	localparam logic [11:0] COARSE_SWING_ADDR = 12'h402;
	localparam logic [11:0] LINK_VARIANT_ADDR = 12'h432;
	localparam logic [11:0] CLOCK_DELAY_ADDR  = 12'h446;
	localparam logic [11:0] DISCHARGE_ADDR    = 12'h448;
	localparam int          ADDR_W            = 12;
	localparam int          DATA_W            = 16;

	// Reset values of whole registers
	localparam logic [15:0] FINE_SWING_RST    = 16'h000a;
	localparam logic [15:0] COARSE_SWING_RST  = 16'h0383;
	localparam logic [15:0] LINK_VARIANT_RST  = 16'h0000;
	localparam logic [15:0] CLOCK_DELAY_RST   = 16'h0077;
	localparam logic [15:0] DISCHARGE_RST     = 16'h0000;
	localparam logic [15:0] RDATA_IDLE        = 16'h0000; // Read port level between reads

	// Writable bit masks; other bits read back their fixed values
	localparam logic [15:0] FINE_SWING_WMASK   = 16'hffff;
	localparam logic [15:0] COARSE_SWING_WMASK = 16'hffff;
	localparam logic [15:0] LINK_VARIANT_WMASK = 16'h7fff;
	localparam logic [15:0] CLOCK_DELAY_WMASK  = 16'h00ff;

	// Field positions
	localparam int FINE_LSB     = 0;
	localparam int COARSE_LSB   = 0;
	localparam int VARIANT_BIT  = 14;
	localparam int TX_DELAY_LSB = 4;
	localparam int RX_DELAY_LSB = 0;
	localparam int NIBBLE_W     = 4;
	localparam int COARSE_W     = 3;
endpackage

// ### src/pdx_reg16.sv
`timescale 1ns/1ps
`default_nettype none
module pdx_reg16 #(
	parameter logic [15:0] RST_VAL = 16'h0000, // Value after reset
	parameter logic [15:0] WMASK   = 16'hffff  // Writable bits
) (
	input  wire logic        clk,   // Device clock
	input  wire logic        rst_b, // Async reset, active low
	input  wire logic        wrEn,  // Write this register
	input  wire logic [15:0] wrData,// Write data
	output logic      [15:0] value  // Stored value
);
	logic [15:0] value_nxt;

	// Masked update keeps read-only bits at their reset value
	always_comb begin
		value_nxt = value;
		if (wrEn) begin
			value_nxt = (wrData & WMASK) | (RST_VAL & ~WMASK);
		end
	end

	// Storage
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			value <= RST_VAL;
		end else begin
			value <= value_nxt;
		end
	end
endmodule
`default_nettype wire

// ### test/tb_phy_driver_xmii_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmpCount++; if ((a) !== (e)) begin failures++; \
	$display("Error at %0t: got %h expected %h", $time, a, e); end end
module tb_phy_driver_xmii_config_regs;
	typedef struct packed {logic [11:0] a; logic [15:0] d; logic [15:0] r; logic [17:0] o;} pdx_row_t;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [11:0] regAddr = 12'h000;
	logic [15:0] regWrData = 16'h0000;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [15:0] regRdData;
	logic [3:0]  fineSwing, txDelay, rxDelay;
	logic [2:0]  coarseSwing;
	logic        sixWireLink, recvClockOutEn;
	logic [17:0] obs;
	int          failures = 0;
	int          cmpCount = 0;
	int          cycles = 0;
	localparam logic [17:0] OUT_RST = {4'ha, 4'h3, 2'h0, 4'h7, 4'h7};
	// Rows carry the running state: each output column follows all writes before it
	pdx_row_t rows [10] = '{
		'{12'h401, 16'h0000, 16'h0000, {4'h0, 4'h3, 2'h0, 4'h7, 4'h7}},
		'{12'h401, 16'h0008, 16'h0008, {4'h8, 4'h3, 2'h0, 4'h7, 4'h7}},
		'{12'h401, 16'hfff9, 16'hfff9, {4'h9, 4'h3, 2'h0, 4'h7, 4'h7}},
		'{12'h402, 16'h0000, 16'h0000, {4'h9, 4'h0, 2'h0, 4'h7, 4'h7}},
		'{12'h402, 16'h0004, 16'h0004, {4'h9, 4'h4, 2'h0, 4'h7, 4'h7}},
		'{12'h402, 16'hffff, 16'hffff, {4'h9, 4'h7, 2'h0, 4'h7, 4'h7}},
		'{12'h432, 16'hffff, 16'h7fff, {4'h9, 4'h7, 2'h3, 4'h7, 4'h7}},
		'{12'h446, 16'hff0f, 16'h000f, {4'h9, 4'h7, 2'h3, 4'h0, 4'hf}},
		'{12'h448, 16'hffff, 16'h0000, {4'h9, 4'h7, 2'h3, 4'h0, 4'hf}},
		'{12'h400, 16'hffff, 16'h0000, {4'h9, 4'h7, 2'h3, 4'h0, 4'hf}}};

	assign obs = {fineSwing, 1'b0, coarseSwing, sixWireLink, recvClockOutEn, txDelay, rxDelay};

	pdx_config_regs u_dut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .fineSwing(fineSwing),
		.coarseSwing(coarseSwing), .sixWireLink(sixWireLink), .recvClockOutEn(recvClockOutEn),
		.txDelay(txDelay), .rxDelay(rxDelay));

	// 40 MHz clock
	always #12.5 clk = ~clk;

	// Strobe left high so a following access needs no idle cycle
	task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] d);
		@(posedge clk);
		regWr <= w;
		regRd <= !w;
		regAddr <= a;
		regWrData <= d;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rdchk(input logic [11:0] a, input logic [15:0] e);
		acc(1'b0, a, 16'h0000);
		@(posedge clk);
		regRd <= 1'b0;
		regWr <= 1'b0;
		#1 `CHK(regRdData, e)
	endtask

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", cmpCount, failures);
		if (failures == 0 && cmpCount > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Hang guard, well beyond the roughly 80 cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			stop_test();
		end
	end

	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		#1 `CHK(obs, OUT_RST)
		rdchk(12'h401, 16'h000a);
		rdchk(12'h402, 16'h0383);
		rdchk(12'h432, 16'h0000);
		rdchk(12'h446, 16'h0077);
		rdchk(12'h448, 16'h0000);
		$display("Reset values done");
		foreach (rows[i]) begin
			acc(1'b1, rows[i].a, rows[i].d);
			rdchk(rows[i].a, rows[i].r);
			@(posedge clk);
			#1 `CHK(obs, rows[i].o)
		end
		$display("Table done");
		// Read straight after write must see the new word
		acc(1'b1, 12'h446, 16'h00f3);
		rdchk(12'h446, 16'h00f3);
		@(posedge clk);
		#1 `CHK({txDelay, rxDelay}, 8'hf3)
		// Second reset in mid-run restores every field
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		#1 `CHK(obs, OUT_RST)
		// Coarse code changed by read-modify-write, reserved bits kept
		rdchk(12'h402, 16'h0383);
		acc(1'b1, 12'h402, (16'h0383 & ~16'h0007) | 16'h0004);
		rdchk(12'h402, 16'h0384);
		@(posedge clk);
		#1 `CHK(coarseSwing, 3'h4)
		$display("Awkward cases done");
		stop_test();
	end
endmodule
`default_nettype wire
